/* File: bench/vcd_top_tb.sv */
// Self-checking bench for the video clock detector register slave.
module vcd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        aclk, aresetn, vid_clk, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [1:0]  vid_div;
  int          fail_count, num_checks;

  vcd_top i_dut
  (
    .aclk(aclk), .aresetn(aresetn), .vid_clk(vid_clk),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // ----------------------------------------------------------------
  // Clock, video source and watchdog
  // ----------------------------------------------------------------
  // Bus clock of 5 ns.
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Video clock of eight bus cycles, slow enough for the two-flop sampler.
  always @(posedge aclk)
  begin
    if (vid_div == 2'h3)
    begin
      vid_div <= 2'h0;
      vid_clk <= ~vid_clk;
    end
    else
      vid_div <= vid_div + 2'h1;
  end

  // A hang costs a mismatch; the tests take well under 5000 cycles.
  initial
  begin
    #50000;
    fail_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Write one word; both channels offered together, each released when taken.
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) fail_count++;
  endtask : axi_wr

  // Read one word; the answer is taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) fail_count++;
  endtask : axi_rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // All three registers read zero out of reset; only the clock count read is checked for OKAY.
  task automatic t_reset();
    axi_rd(vcd_pkg::COUNT_ENABLE_OFF);
    check(rd, 32'h0);
    axi_rd(vcd_pkg::DURATION_OFF);
    check(rd, 32'h0);
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    check(rd, 32'h0);
    check(rs, vcd_pkg::RESP_OKAY);
  endtask : t_reset

  // Access kinds, byte lanes, the read-only word and an unmapped word.
  task automatic t_regs();
    axi_wr(vcd_pkg::DURATION_OFF, 32'hA5A5_5A5A, 4'hF);
    check(rs, vcd_pkg::RESP_OKAY);
    axi_rd(vcd_pkg::DURATION_OFF);
    check(rd, 32'hA5A5_5A5A);
    axi_wr(vcd_pkg::DURATION_OFF, 32'hFFFF_FFFF, 4'h3);
    axi_rd(vcd_pkg::DURATION_OFF);
    check(rd, 32'hA5A5_FFFF);
    axi_wr(vcd_pkg::COUNT_ENABLE_OFF, 32'hFFFF_FFFF, 4'hF);
    check(rs, vcd_pkg::RESP_OKAY);
    axi_rd(vcd_pkg::COUNT_ENABLE_OFF);
    check(rd, 32'h1);
    axi_wr(vcd_pkg::COUNT_ENABLE_OFF, 32'h0, 4'hF);
    axi_rd(vcd_pkg::COUNT_ENABLE_OFF);
    check(rd, 32'h0);
    axi_wr(vcd_pkg::CLOCK_COUNT_OFF, 32'h1234_5678, 4'hF);
    check(rs, vcd_pkg::RESP_SLVERR);
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    check(rd, 32'h0);
    axi_rd(5'h04);
    check(rs, vcd_pkg::RESP_SLVERR);
    check(rd, 32'h0);
  endtask : t_regs

  // One measurement: zero while aligning, a count near the expected ratio
  // after the second wrap, then frozen for a further window.
  task automatic t_measure(input logic [31:0] dur, input logic [31:0] lo,
                           input logic [31:0] hi);
    logic [31:0] first;
    axi_wr(vcd_pkg::DURATION_OFF, dur, 4'hF);
    axi_wr(vcd_pkg::COUNT_ENABLE_OFF, 32'h1, 4'hF);
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    check(rd, 32'h0);
    repeat (3 * (dur + 1) + 20) @(posedge aclk);
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    first = rd;
    check(32'(first >= lo && first <= hi), 32'h1);
    repeat (dur + 1) @(posedge aclk);
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    check(rd, first);
    axi_wr(vcd_pkg::COUNT_ENABLE_OFF, 32'h0, 4'hF);
  endtask : t_measure

  // A reset in mid-run must wipe a held count and a programmed duration,
  // which the first reset cannot show because both start at zero.
  task automatic t_mid_reset();
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    check(32'(rd != 32'h0), 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(vcd_pkg::CLOCK_COUNT_OFF);
    check(rd, 32'h0);
    axi_rd(vcd_pkg::DURATION_OFF);
    check(rd, 32'h0);
    axi_rd(vcd_pkg::COUNT_ENABLE_OFF);
    check(rd, 32'h0);
  endtask : t_mid_reset

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial
  begin
    aresetn    = 1'b0;
    vid_clk    = 1'b0;
    vid_div    = 2'h0;
    awaddr     = 5'h00;
    awvalid    = 1'b0;
    wdata      = 32'h0;
    wstrb      = 4'h0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    araddr     = 5'h00;
    arvalid    = 1'b0;
    rready     = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    // Windows of 100 and 200 bus cycles against an eight-cycle video period.
    t_measure(32'd99, 32'd12, 32'd13);
    t_measure(32'd199, 32'd24, 32'd26);
    t_mid_reset();
    print_verdict();
  end

endmodule : vcd_top_tb

/* File: hw/vcd_pkg.sv */
// Package with register map, reset values and encodings of the video clock detector.
package vcd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W           = 5;
  localparam logic [4:0]    COUNT_ENABLE_OFF = 5'h00;
  localparam logic [4:0]    CLOCK_COUNT_OFF  = 5'h08;
  localparam logic [4:0]    DURATION_OFF     = 5'h18;
  localparam int unsigned   ENABLE_BIT       = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic          ENABLE_RST       = 1'h0;
  localparam logic [31:0]   DURATION_RST     = 32'h0000_0000;
  localparam logic [31:0]   CLOCK_COUNT_RST  = 32'h0000_0000;
  localparam logic [31:0]   EVENT_COUNT_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]    RESP_OKAY        = 2'h0;
  localparam logic [1:0]    RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // Measurement phases, Gray coded along idle, arm, measure, done
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    VCD_IDLE    = 2'h0,
    VCD_ARM     = 2'h1,
    VCD_MEASURE = 2'h3,
    VCD_DONE    = 2'h2
  } vcd_phase_t;

endpackage : vcd_pkg

/* File: hw/vcd_top.sv */
// Video clock detector: AXI4-Lite register slave with event window and clock counter.
//
// Notes on behaviour
// - Bit 0 at offset 0x00 enables event counter.
// - Offset 0x18 holds 32-bit duration, reset zero.
// - Event counter restarts from zero at duration.
// - Clock counter counts only in following re-count.
// - Offset 0x08 reads 32-bit clock count, reset zero.
//
// Implementation choice: the AXI4-Lite slave port.
module vcd_top
(
  input  wire logic        aclk,     // Bus clock, 200 MHz.
  input  wire logic        aresetn,  // Synchronous reset, active low.
  input  wire logic        vid_clk,  // Measured video clock, sampled as data.
  input  wire logic [4:0]  awaddr,   // Write address.
  input  wire logic        awvalid,  // Write address valid.
  output logic             awready,  // Write address ready.
  input  wire logic [31:0] wdata,    // Write data.
  input  wire logic [3:0]  wstrb,    // Write byte strobes.
  input  wire logic        wvalid,   // Write data valid.
  output logic             wready,   // Write data ready.
  output logic [1:0]       bresp,    // Write response code.
  output logic             bvalid,   // Write response valid.
  input  wire logic        bready,   // Write response ready.
  input  wire logic [4:0]  araddr,   // Read address.
  input  wire logic        arvalid,  // Read address valid.
  output logic             arready,  // Read address ready.
  output logic [31:0]      rdata,    // Read data.
  output logic [1:0]       rresp,    // Read response code.
  output logic             rvalid,   // Read data valid.
  input  wire logic        rready    // Read data ready.
);

  logic                    awready_ff;
  logic                    wready_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic [1:0]              rresp_ff;
  logic [31:0]             rdata_ff;
  logic                    aw_got_ff;
  logic                    w_got_ff;
  logic [4:0]              waddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    wr_fire;
  logic                    en_ff;
  logic [31:0]             dur_ff;
  logic [31:0]             evt_cnt_ff;
  logic [31:0]             clk_cnt_ff;
  logic                    evt_wrap;
  logic                    vid_meta_ff;
  logic                    vid_sync_ff;
  logic                    vid_prev_ff;
  logic                    vid_rise;
  vcd_pkg::vcd_phase_t     phase_ff;
  vcd_pkg::vcd_phase_t     nxt_phase;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------

  // Address and data are caught independently, so either may come first.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      waddr_ff   <= 5'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      if (awvalid && awready_ff)
      begin
        aw_got_ff  <= 1'b1;
        awready_ff <= 1'b0;
        waddr_ff   <= awaddr;
      end
      if (wvalid && wready_ff)
      begin
        w_got_ff  <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
      end
      if (bvalid_ff && bready)
      begin
        aw_got_ff  <= 1'b0;
        w_got_ff   <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // A write commits once both halves are held and no answer is pending.
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

  // Only the two writable words answer OKAY; the count word is read only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= vcd_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (waddr_ff[4:2] == vcd_pkg::COUNT_ENABLE_OFF[4:2] ||
                    waddr_ff[4:2] == vcd_pkg::DURATION_OFF[4:2]) ?
                   vcd_pkg::RESP_OKAY : vcd_pkg::RESP_SLVERR;
    end
    else if (bvalid_ff && bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // The enable lives in the lowest byte, so only strobe 0 matters.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      en_ff <= vcd_pkg::ENABLE_RST;
    else if (wr_fire && waddr_ff[4:2] == vcd_pkg::COUNT_ENABLE_OFF[4:2] && wstrb_ff[0])
      en_ff <= wdata_ff[vcd_pkg::ENABLE_BIT];
  end

  // The duration honours each byte strobe separately.
  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_dur_byte
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          dur_ff[8*b +: 8] <= vcd_pkg::DURATION_RST[8*b +: 8];
        else if (wr_fire && waddr_ff[4:2] == vcd_pkg::DURATION_OFF[4:2] && wstrb_ff[b])
          dur_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------

  // Reads answer one cycle after the address is taken; unmapped words give SLVERR.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= vcd_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end
    else if (arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= vcd_pkg::RESP_OKAY;
      unique case (araddr[4:2])
        vcd_pkg::COUNT_ENABLE_OFF[4:2]: rdata_ff <= {31'h0000_0000, en_ff};
        vcd_pkg::CLOCK_COUNT_OFF[4:2]:  rdata_ff <= clk_cnt_ff;
        vcd_pkg::DURATION_OFF[4:2]:     rdata_ff <= dur_ff;
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= vcd_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && rready)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Video clock sampling
  // ----------------------------------------------------------------

  // Two stages tame metastability; the video clock must stay below half of aclk.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vid_meta_ff <= 1'b0;
      vid_sync_ff <= 1'b0;
      vid_prev_ff <= 1'b0;
    end
    else
    begin
      vid_meta_ff <= vid_clk;
      vid_sync_ff <= vid_meta_ff;
      vid_prev_ff <= vid_sync_ff;
    end
  end

  assign vid_rise = vid_sync_ff && !vid_prev_ff;

  // ----------------------------------------------------------------
  // Event window and measurement phase
  // ----------------------------------------------------------------

  assign evt_wrap = en_ff && (evt_cnt_ff == dur_ff);

  // The event counter ticks on aclk, wraps at the duration and keeps going.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_ff)
      evt_cnt_ff <= vcd_pkg::EVENT_COUNT_RST;
    else if (evt_wrap)
      evt_cnt_ff <= 32'h0000_0000;
    else
      evt_cnt_ff <= evt_cnt_ff + 32'h0000_0001;
  end

  // The first window only aligns; the next one measures, then the result is held.
  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      vcd_pkg::VCD_IDLE:    if (en_ff) nxt_phase = vcd_pkg::VCD_ARM;
      vcd_pkg::VCD_ARM:     if (evt_wrap) nxt_phase = vcd_pkg::VCD_MEASURE;
      vcd_pkg::VCD_MEASURE: if (evt_wrap) nxt_phase = vcd_pkg::VCD_DONE;
      vcd_pkg::VCD_DONE:    nxt_phase = vcd_pkg::VCD_DONE;
    endcase
    if (!en_ff)
      nxt_phase = vcd_pkg::VCD_IDLE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_ff <= vcd_pkg::VCD_IDLE;
    else
      phase_ff <= nxt_phase;
  end

  // The clock counter clears while armed and counts only in the re-count window.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clk_cnt_ff <= vcd_pkg::CLOCK_COUNT_RST;
    else if (phase_ff == vcd_pkg::VCD_ARM)
      clk_cnt_ff <= 32'h0000_0000;
    else if (phase_ff == vcd_pkg::VCD_MEASURE && vid_rise)
      clk_cnt_ff <= clk_cnt_ff + 32'h0000_0001;
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  enable_off_clear_a: assert property (!en_ff |=> evt_cnt_ff == 32'h0000_0000)
    else $error("Event counter not cleared while disabled.");
  event_step_a: assert property (en_ff && !evt_wrap |=>
      evt_cnt_ff == $past(evt_cnt_ff) + 32'h0000_0001)
    else $error("Event counter did not advance.");
  event_wrap_a: assert property (evt_wrap |=> evt_cnt_ff == 32'h0000_0000)
    else $error("Event counter did not restart at duration.");
  duration_write_a: assert property (wr_fire && wstrb_ff == 4'hF &&
      waddr_ff == vcd_pkg::DURATION_OFF |=> dur_ff == $past(wdata_ff))
    else $error("Duration write not stored.");
  measure_start_a: assert property (phase_ff == vcd_pkg::VCD_ARM && evt_wrap
      |=> phase_ff == vcd_pkg::VCD_MEASURE ##1 clk_cnt_ff <= 32'h0000_0001)
    else $error("Measurement window did not open.");
  count_hold_a: assert property (phase_ff == vcd_pkg::VCD_DONE && en_ff
      |=> $stable(clk_cnt_ff))
    else $error("Clock counter moved outside the window.");
  count_step_a: assert property (phase_ff == vcd_pkg::VCD_MEASURE && vid_rise
      |=> clk_cnt_ff == $past(clk_cnt_ff) + 32'h0000_0001)
    else $error("Clock counter missed a video edge.");
  count_read_a: assert property (arvalid && arready_ff &&
      araddr == vcd_pkg::CLOCK_COUNT_OFF |=> rvalid_ff && rdata_ff == $past(clk_cnt_ff))
    else $error("Clock count read returned wrong data.");
  write_answer_a: assert property (wr_fire |=> bvalid_ff [*1] ##0 !awready_ff)
    else $error("Write response missing.");

  measure_done_c: cover property (phase_ff == vcd_pkg::VCD_MEASURE ##1
      phase_ff == vcd_pkg::VCD_DONE);
  count_read_c: cover property (rvalid_ff && rready && rdata_ff != 32'h0000_0000);
  write_order_c: cover property (w_got_ff && !aw_got_ff ##1 aw_got_ff);

endmodule : vcd_top
